// >>> sirm_regs.svh
// register offsets, field positions, reset values and timing counts of the supply integrity monitor
// Contract
// - enabled detector holds reset below hysteresis threshold
// - power-on and drop resets both drive pin; here power-on only clears the lock flag
// - supply glitches shorter than filter ignored
// - reset pin low throughout supply fault
// - watchdog underflow gives minimum low pulse
// - illegal opcode or prebyte also resets
// - option bit selects detector presence
// - option selects low, medium, high threshold
// - warning flag is read-only comparator output
// - warning works only with detector enabled
// - warning threshold follows detector level
// - crossing sets flag, enabled raises interrupt
// - interrupt needs enable and cleared mask
// - wait mode normal, warning wakes
// - halt freezes register, warning inactive; here the cause and lock flags still follow their events in halt
// - eight-bit layout, bit seven kept clear
// - watchdog flag set, cleared by read/fault
// - fault flag set, cleared by read only
// - lock flag set by pll, power-on clears
// - pending warning cleared on service entry
`ifndef SIRM_REGS_SVH
`define SIRM_REGS_SVH
`define SIRM_CTRL_STATUS_OFFSET 12'h000
`define SIRM_BIT_IRQ_EN 0
`define SIRM_BIT_WARN_FLAG 1
`define SIRM_BIT_LOW_RST_FLAG 2
`define SIRM_BIT_PLL_LOCK 3
`define SIRM_BIT_WDG_FLAG 4
`define SIRM_BIT_TRIM_LO 5
`define SIRM_BIT_TRIM_HI 6
`define SIRM_CTRL_RESET 8'h60
`define SIRM_GLITCH_NS 200
`define SIRM_WDG_PULSE_NS 30000
`define SIRM_CLK_NS 25
`define SIRM_GLITCH_CYC ((`SIRM_GLITCH_NS + `SIRM_CLK_NS - 1) / `SIRM_CLK_NS)
`define SIRM_WDG_PULSE_CYC ((`SIRM_WDG_PULSE_NS + `SIRM_CLK_NS - 1) / `SIRM_CLK_NS)
`endif

// >>> sirm_pkg.sv
// types of the supply integrity monitor
package sirm_pkg;
  typedef enum logic [1:0] {
    SIRM_LVL_LOW = 2'b00,
    SIRM_LVL_MED = 2'b01,
    SIRM_LVL_HIGH = 2'b10
  } sirm_level_type;
  typedef enum logic [1:0] {
    SIRM_ST_RUN = 2'b00,
    SIRM_ST_FAULT = 2'b01,
    SIRM_ST_WDG = 2'b11
  } sirm_state_type;
endpackage

// >>> sirm_sync_filter.sv
// two-flop synchroniser plus stability filter for a comparator level
`timescale 1ns/1ps
module sirm_sync_filter #(
  parameter int FILTER_CYC = 8,
  parameter bit RESET_VAL = 1'b0
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // raw and filtered level
  input wire logic i_level,
  output logic o_level
);
  localparam int CW = $clog2(FILTER_CYC + 1);
  initial
  begin
    if (FILTER_CYC < 1)
      $error("filter length must be at least one");
  end
  logic meta_reg;
  logic sync_reg;
  logic out_reg;
  logic [CW-1:0] cnt_reg;
  wire differs = sync_reg != out_reg;
  wire expired = cnt_reg == CW'(FILTER_CYC - 1);
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      meta_reg <= RESET_VAL;
      sync_reg <= RESET_VAL;
      out_reg <= RESET_VAL;
      cnt_reg <= '0;
    end
    else
    begin
      meta_reg <= i_level;
      sync_reg <= meta_reg;
      // level must hold for the full filter time before it is accepted
      cnt_reg <= (differs && !expired) ? cnt_reg + 1'b1 : '0;
      if (differs && expired)
        out_reg <= sync_reg;
    end
  end
  assign o_level = out_reg;
endmodule

// >>> sirm_top.sv
// supply integrity reset monitor: reset pin control, reset-cause flags, supply warning, APB register
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "sirm_regs.svh"
module sirm_top #(
  parameter int GLITCH_CYC = `SIRM_GLITCH_CYC,
  parameter int WDG_PULSE_CYC = `SIRM_WDG_PULSE_CYC
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // nonvolatile options
  input wire logic i_opt_detector_en,
  input wire logic [1:0] i_opt_level,
  // analog comparators (asynchronous)
  input wire logic i_low_supply_cmp,
  input wire logic i_aux_supply_cmp,
  output logic [1:0] o_threshold_sel,
  output logic o_aux_detector_en,
  // reset sources
  input wire logic i_power_on,
  input wire logic i_wdg_underflow,
  input wire logic i_illegal_op,
  input wire logic i_pll_locked,
  // reset pin, open drain
  input wire logic i_reset_pin,
  output logic o_reset_pin,
  output logic o_reset_pin_oe,
  output logic o_core_reset,
  // core interrupt interface and power modes
  input wire logic i_global_irq_mask,
  input wire logic i_irq_ack,
  input wire logic i_wait_mode,
  input wire logic i_halt_mode,
  output logic o_warn_irq,
  output logic o_wait_wake,
  output logic [1:0] o_osc_trim
);
  localparam int PW = $clog2(WDG_PULSE_CYC + 1);
  initial
  begin
    if (WDG_PULSE_CYC < 1 || GLITCH_CYC < 1)
      $error("timing counts must be at least one");
  end

  // filtered comparator levels; low_supply high means supply below threshold
  logic low_filt;
  logic aux_filt;
  logic reset_pin_meta_reg;
  logic reset_pin_sync_reg;
  sirm_sync_filter #(.FILTER_CYC(GLITCH_CYC), .RESET_VAL(1'b1)) u_low_filter (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_level(i_low_supply_cmp),
    .o_level(low_filt)
  );
  sirm_sync_filter #(.FILTER_CYC(GLITCH_CYC), .RESET_VAL(1'b0)) u_aux_filter (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_level(i_aux_supply_cmp),
    .o_level(aux_filt)
  );

  // option handling: an unused detector never produces a fault
  wire supply_fault = i_opt_detector_en && low_filt;
  wire sirm_pkg::sirm_level_type level_sel = (i_opt_level == 2'b11) ? sirm_pkg::SIRM_LVL_HIGH
    : sirm_pkg::sirm_level_type'(i_opt_level);
  assign o_threshold_sel = level_sel;
  assign o_aux_detector_en = i_opt_detector_en && !i_halt_mode;

  // reset sequencer
  sirm_pkg::sirm_state_type state_reg;
  sirm_pkg::sirm_state_type state_next;
  logic [PW-1:0] pulse_reg;
  logic [PW-1:0] pulse_next;
  logic power_on_reg;
  logic power_on_meta_reg;
  logic pll_meta_reg;
  logic pll_sync_reg;
  wire wdg_done = pulse_reg == PW'(WDG_PULSE_CYC - 1);
  always_comb
  begin
    state_next = state_reg;
    pulse_next = '0;
    unique case (state_reg)
      sirm_pkg::SIRM_ST_RUN:
      begin
        if (supply_fault)
          state_next = sirm_pkg::SIRM_ST_FAULT;
        else if (i_wdg_underflow || i_illegal_op)
          state_next = sirm_pkg::SIRM_ST_WDG;
      end
      sirm_pkg::SIRM_ST_FAULT:
      begin
        if (!supply_fault)
          state_next = sirm_pkg::SIRM_ST_RUN;
      end
      sirm_pkg::SIRM_ST_WDG:
      begin
        pulse_next = wdg_done ? pulse_reg : pulse_reg + 1'b1;
        if (supply_fault)
          state_next = sirm_pkg::SIRM_ST_FAULT;
        else if (wdg_done)
          state_next = sirm_pkg::SIRM_ST_RUN;
      end
      default:
        state_next = sirm_pkg::SIRM_ST_RUN;
    endcase
  end
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      state_reg <= sirm_pkg::SIRM_ST_RUN;
      pulse_reg <= '0;
      reset_pin_meta_reg <= 1'b1;
      reset_pin_sync_reg <= 1'b1;
      power_on_meta_reg <= 1'b0;
      power_on_reg <= 1'b0;
      pll_meta_reg <= 1'b0;
      pll_sync_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      pulse_reg <= pulse_next;
      reset_pin_meta_reg <= i_reset_pin;
      reset_pin_sync_reg <= reset_pin_meta_reg;
      // power-on and lock levels come from analog and another clock
      power_on_meta_reg <= i_power_on;
      power_on_reg <= power_on_meta_reg;
      pll_meta_reg <= i_pll_locked;
      pll_sync_reg <= pll_meta_reg;
    end
  end
  wire pin_drive = state_reg != sirm_pkg::SIRM_ST_RUN;
  assign o_reset_pin = 1'b0;
  assign o_reset_pin_oe = pin_drive;
  assign o_core_reset = pin_drive || !reset_pin_sync_reg;

  // apb decode
  wire hit = i_paddr == `SIRM_CTRL_STATUS_OFFSET;
  wire access = i_psel && i_penable;
  wire wr_ctrl = access && i_pwrite && hit && i_pstrb[0];
  wire rd_ctrl = access && !i_pwrite && hit;
  // a supply fault during a watchdog pulse is still a supply-fault reset
  wire fault_event = state_reg != sirm_pkg::SIRM_ST_FAULT && state_next == sirm_pkg::SIRM_ST_FAULT;
  wire wdg_event = state_reg == sirm_pkg::SIRM_ST_RUN && state_next == sirm_pkg::SIRM_ST_WDG;
  wire frozen = i_halt_mode;

  // control/status register fields
  logic irq_en_reg;
  logic warn_flag_reg;
  logic low_rst_flag_reg;
  logic pll_lock_reg;
  logic wdg_flag_reg;
  logic [1:0] trim_reg;
  logic warn_pend_reg;
  wire warn_now = o_aux_detector_en && aux_filt;
  wire warn_rise = warn_now && !warn_flag_reg;
  wire [7:0] ctrl_status = {1'b0, trim_reg, wdg_flag_reg, pll_lock_reg, low_rst_flag_reg,
    warn_flag_reg, irq_en_reg};
  wire rd_clear = rd_ctrl && !frozen;
  always_ff @(posedge i_mclk)
  begin
    if (i_rst || power_on_reg)
      pll_lock_reg <= 1'b0;
    else if (pll_sync_reg)
      pll_lock_reg <= 1'b1;
  end
  // set wins over clear-by-read for both cause flags
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      low_rst_flag_reg <= 1'b0;
    else if (fault_event)
      low_rst_flag_reg <= 1'b1;
    else if (rd_clear)
      low_rst_flag_reg <= 1'b0;
  end
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      wdg_flag_reg <= 1'b0;
    else if (wdg_event)
      wdg_flag_reg <= 1'b1;
    else if (fault_event || rd_clear)
      wdg_flag_reg <= 1'b0;
  end
  // halt freezes the warning flag, the writable fields and the pending request
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      warn_flag_reg <= 1'b0;
    else if (!frozen)
      warn_flag_reg <= warn_now;
  end
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      irq_en_reg <= 1'b0;
      trim_reg <= 2'(`SIRM_CTRL_RESET >> `SIRM_BIT_TRIM_LO);
    end
    else if (wr_ctrl && !frozen)
    begin
      irq_en_reg <= i_pwdata[`SIRM_BIT_IRQ_EN];
      trim_reg <= i_pwdata[`SIRM_BIT_TRIM_HI:`SIRM_BIT_TRIM_LO];
    end
  end
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      warn_pend_reg <= 1'b0;
    else if (!frozen && warn_rise)
      warn_pend_reg <= 1'b1;
    else if (!frozen && i_irq_ack)
      warn_pend_reg <= 1'b0;
  end
  wire irq_req = warn_pend_reg && irq_en_reg && !frozen;
  assign o_warn_irq = irq_req && !i_global_irq_mask;
  assign o_wait_wake = o_warn_irq && i_wait_mode;
  assign o_osc_trim = trim_reg;

  // apb answer: zero wait states, unmapped reads zero with error
  logic [31:0] prdata_reg;
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      prdata_reg <= 32'h0000_0000;
    else if (i_psel && !i_penable && !i_pwrite)
      prdata_reg <= (i_paddr == `SIRM_CTRL_STATUS_OFFSET) ? {24'h00_0000, ctrl_status} : 32'h0000_0000;
  end
  assign o_prdata = prdata_reg;
  assign o_pready = 1'b1;
  assign o_pslverr = access && !hit;
endmodule

// >>> sirm_core_model.sv
// cpu service entry and pulled-up reset pin facing the monitor
`timescale 1ns/1ps
module sirm_core_model (
  // clock, reset and request
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_warn_irq,
  // reset pin drivers
  input wire logic i_pin_oe,
  input wire logic i_ext_low,
  // service entry and pin level
  output logic o_irq_ack,
  output logic o_pin
);
  logic seen_reg;
  // pull-up: any party pulling low wins
  assign o_pin = !(i_pin_oe || i_ext_low);
  always_ff @(posedge i_mclk)
  begin
    seen_reg <= i_warn_irq && !i_rst;
    // one-cycle service entry, one cycle after the request is seen
    o_irq_ack <= seen_reg && i_warn_irq && !o_irq_ack && !i_rst;
  end
endmodule

// >>> sirm_top_sva.sv
// port assertions of the supply integrity monitor
`timescale 1ns/1ps
module sirm_top_sva #(
  parameter int GLITCH_CYC = 8,
  parameter int WDG_PULSE_CYC = 4
) (
  // clock, reset and bus
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [11:0] i_paddr,
  input wire logic o_pslverr,
  // options and reset sources
  input wire logic i_opt_detector_en,
  input wire logic [1:0] i_opt_level,
  input wire logic i_low_supply_cmp,
  input wire logic [1:0] o_threshold_sel,
  input wire logic o_aux_detector_en,
  input wire logic i_wdg_underflow,
  input wire logic i_illegal_op,
  input wire logic o_reset_pin,
  input wire logic o_reset_pin_oe,
  input wire logic o_core_reset,
  // core side
  input wire logic i_global_irq_mask,
  input wire logic i_wait_mode,
  input wire logic i_halt_mode,
  input wire logic o_warn_irq,
  input wire logic o_wait_wake
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  a_pulse_min: assert property ((i_wdg_underflow || i_illegal_op) |=> o_reset_pin_oe [*4])
    else $error("short reset pulse");
  a_pin_drive: assert property (o_reset_pin_oe |-> !o_reset_pin && o_core_reset)
    else $error("pin not driven low");
  a_fault_cause: assert property ($rose(o_reset_pin_oe) |-> $past(i_wdg_underflow) || $past(i_illegal_op)
    || (i_opt_detector_en && ($past(i_low_supply_cmp) || $past(i_rst, 2)))) else $error("reset without cause");
  a_irq_gate: assert property (o_warn_irq |-> !i_global_irq_mask) else $error("masked irq");
  a_aux_enable: assert property (o_aux_detector_en == (i_opt_detector_en && !i_halt_mode))
    else $error("aux enable wrong");
  a_level_follow: assert property (o_threshold_sel == ((i_opt_level == 2'b11) ? 2'b10 : i_opt_level))
    else $error("level wrong");
  a_unmapped_err: assert property (i_psel && i_penable && i_paddr != 12'h000 |-> o_pslverr)
    else $error("no slave error");
  a_wake_irq: assert property (o_warn_irq && i_wait_mode |-> o_wait_wake) else $error("no wake");
  a_halt_quiet: assert property (i_halt_mode |-> !o_warn_irq && !o_aux_detector_en)
    else $error("warning active in halt");
  cover property (o_warn_irq && i_wait_mode);
  cover property (i_wdg_underflow ##1 o_reset_pin_oe);
  cover property (o_pslverr);
endmodule
bind sirm_top sirm_top_sva #(.GLITCH_CYC(GLITCH_CYC), .WDG_PULSE_CYC(WDG_PULSE_CYC)) chk_u (.i_mclk, .i_rst,
  .i_psel, .i_penable, .i_paddr, .o_pslverr, .i_opt_detector_en, .i_opt_level, .i_low_supply_cmp,
  .o_threshold_sel, .o_aux_detector_en, .i_wdg_underflow, .i_illegal_op, .o_reset_pin, .o_reset_pin_oe,
  .o_core_reset, .i_global_irq_mask, .i_wait_mode, .i_halt_mode, .o_warn_irq, .o_wait_wake);

// >>> tb_supply_integrity_reset_monitor.sv
// bench of the supply integrity monitor
`timescale 1ns/1ps
module tb_supply_integrity_reset_monitor;
  typedef struct {logic w; logic [11:0] a; logic [31:0] d, e; logic r;} sirm_row_type;
  logic i_mclk = 1'h0, i_rst = 1'h1, i_psel = 1'h0, i_penable = 1'h0, i_pwrite = 1'h0;
  logic i_opt_detector_en = 1'h1, i_low_supply_cmp = 1'h0, i_aux_supply_cmp = 1'h0;
  logic i_wdg_underflow = 1'h0, i_illegal_op = 1'h0, i_global_irq_mask = 1'h1, i_wait_mode = 1'h0;
  logic [1:0] i_opt_level = 2'h1, o_threshold_sel, o_osc_trim;
  logic i_halt_mode = 1'h0, i_pll_locked = 1'h0, i_power_on = 1'h0, i_ext_low = 1'h0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0000_0000, o_prdata, rd;
  logic o_pready, o_pslverr, o_aux_detector_en, o_reset_pin, o_reset_pin_oe, o_core_reset;
  logic o_warn_irq, o_wait_wake, i_irq_ack, i_reset_pin, er;
  int n_mismatch = 0, checks = 0, n;
  sirm_row_type rows [6] = '{
    // detector filter leaves reset at below, so the first read shows the fault flag
    '{1'h0, 12'h000, 32'h0000_0000, 32'h0000_0064, 1'h0},
    '{1'h1, 12'h000, 32'h0000_00ff, 32'h0000_0000, 1'h0},
    '{1'h0, 12'h000, 32'h0000_0000, 32'h0000_0061, 1'h0},
    '{1'h1, 12'h004, 32'h0000_0000, 32'h0000_0000, 1'h1},
    '{1'h0, 12'h004, 32'h0000_0000, 32'h0000_0000, 1'h1},
    '{1'h0, 12'h000, 32'h0000_0000, 32'h0000_0061, 1'h0}};
  sirm_top #(.GLITCH_CYC(8), .WDG_PULSE_CYC(4)) dut_u (.i_mclk, .i_rst, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .i_pstrb(4'hf), .o_prdata, .o_pready, .o_pslverr, .i_opt_detector_en,
    .i_opt_level, .i_low_supply_cmp, .i_aux_supply_cmp, .o_threshold_sel, .o_aux_detector_en,
    .i_power_on, .i_wdg_underflow, .i_illegal_op, .i_pll_locked, .i_reset_pin, .o_reset_pin,
    .o_reset_pin_oe, .o_core_reset, .i_global_irq_mask, .i_irq_ack, .i_wait_mode, .i_halt_mode,
    .o_warn_irq, .o_wait_wake, .o_osc_trim);
  sirm_core_model model_u (.i_mclk, .i_rst, .i_warn_irq(o_warn_irq), .i_pin_oe(o_reset_pin_oe),
    .i_ext_low, .o_irq_ack(i_irq_ack), .o_pin(i_reset_pin));
  initial
  begin
    forever #12.5 i_mclk = ~i_mclk;
  end
  task automatic chk(input string s, input logic [31:0] v, x);
    checks++;
    if (v !== x)
    begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", s, x, v);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    i_psel <= 1'h1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_mclk);
    i_penable <= 1'h1;
    do
      @(posedge i_mclk);
    while (o_pready !== 1'h1);
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'h0;
    i_penable <= 1'h0;
    @(posedge i_mclk);
  endtask
  // count cycles with the reset pin pulled low
  task automatic cnt(input int c);
    n = 0;
    repeat (c)
    begin
      @(posedge i_mclk);
      n += o_reset_pin_oe;
    end
  endtask
  initial
  begin
    #40us;
    n_mismatch++;
    tally_and_finish;
  end
  initial
  begin
    repeat (6) @(posedge i_mclk);
    i_rst <= 1'h0;
    @(posedge i_mclk);
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk("err", 32'(er), 32'(rows[i].r));
      if (!rows[i].w)
        chk("rdata", rd, rows[i].e);
    end
    for (int v = 0; v < 3; v++)
    begin
      i_opt_level <= 2'(v);
      @(posedge i_mclk);
      chk("level", 32'(o_threshold_sel), v);
    end
    i_aux_supply_cmp <= 1'h1;
    i_wait_mode <= 1'h1;
    repeat (20) @(posedge i_mclk);
    chk("masked", 32'(o_warn_irq), 0);
    apb(1'h0, 12'h000, 32'h0000_0000);
    chk("flag", rd, 32'h0000_0063);
    i_global_irq_mask <= 1'h0;
    @(posedge i_mclk);
    #1 chk("wake", 32'({o_warn_irq, o_wait_wake}), 3);
    repeat (8) @(posedge i_mclk);
    chk("acked", 32'(o_warn_irq), 0);
    i_aux_supply_cmp <= 1'h0;
    i_wait_mode <= 1'h0;
    for (int s = 0; s < 2; s++)
    begin
      i_wdg_underflow <= (s == 0);
      i_illegal_op <= (s == 1);
      @(posedge i_mclk);
      i_wdg_underflow <= 1'h0;
      i_illegal_op <= 1'h0;
      cnt(20);
      chk("pulse", n, 4);
      apb(1'h0, 12'h000, 32'h0000_0000);
      chk("wdg flag", rd, 32'h0000_0071);
    end
    apb(1'h0, 12'h000, 32'h0000_0000);
    chk("cleared", rd, 32'h0000_0061);
    i_low_supply_cmp <= 1'h1;
    repeat (3) @(posedge i_mclk);
    i_low_supply_cmp <= 1'h0;
    cnt(20);
    chk("glitch", n, 0);
    i_low_supply_cmp <= 1'h1;
    repeat (15) @(posedge i_mclk);
    cnt(30);
    chk("hold", n, 30);
    i_low_supply_cmp <= 1'h0;
    cnt(20);
    chk("release", 32'(o_reset_pin_oe), 0);
    i_ext_low <= 1'h1;
    repeat (3) @(posedge i_mclk);
    chk("ext reset", 32'(o_core_reset), 1);
    i_ext_low <= 1'h0;
    repeat (3) @(posedge i_mclk);
    apb(1'h0, 12'h000, 32'h0000_0000);
    chk("fault flag", 32'(rd[4:2]), 1);
    apb(1'h0, 12'h000, 32'h0000_0000);
    chk("fault clr", 32'(rd[4:2]), 0);
    i_pll_locked <= 1'h1;
    repeat (3) @(posedge i_mclk);
    i_pll_locked <= 1'h0;
    apb(1'h0, 12'h000, 32'h0000_0000);
    chk("lock", rd, 32'h0000_0069);
    chk("trim", 32'(o_osc_trim), 3);
    i_halt_mode <= 1'h1;
    i_wdg_underflow <= 1'h1;
    @(posedge i_mclk);
    i_wdg_underflow <= 1'h0;
    cnt(10);
    apb(1'h1, 12'h000, 32'h0000_0000);
    apb(1'h0, 12'h000, 32'h0000_0000);
    apb(1'h0, 12'h000, 32'h0000_0000);
    chk("frozen", rd, 32'h0000_0079);
    chk("trim held", 32'(o_osc_trim), 3);
    i_halt_mode <= 1'h0;
    i_power_on <= 1'h1;
    repeat (3) @(posedge i_mclk);
    i_power_on <= 1'h0;
    apb(1'h0, 12'h000, 32'h0000_0000);
    chk("power on", rd, 32'h0000_0071);
    i_opt_detector_en <= 1'h0;
    @(posedge i_mclk);
    i_low_supply_cmp <= 1'h1;
    i_aux_supply_cmp <= 1'h1;
    cnt(30);
    chk("disabled", n + o_warn_irq, 0);
    tally_and_finish;
  end
endmodule
